// ### pmec_count16.sv
// saturating 16-bit event counter read as upper then lower byte
module pmec_count16 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_event,
   input wire logic i_rd_hi,
   input wire logic i_rd_lo,
   output logic [7:0] o_hi,
   output logic [7:0] o_lo,
   output logic o_sat
);
   import pmec_pkg::*;

   logic [15:0] count;
   logic [7:0] hold;

   // upper-byte read clears the live count; the event of that cycle survives
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count <= CNT16_RST;
      end else if (i_rd_hi) begin
         count <= {15'h0000, i_event};
      end else if (i_event && count != CNT16_MAX) begin
         count <= count + 16'h0001;
      end
   end

   // lower byte frozen at the upper-byte read so the pair matches
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hold <= CNT8_RST;
      end else if (i_rd_hi) begin
         hold <= count[7:0];
      end else if (i_rd_lo) begin
         hold <= CNT8_RST;
      end
   end

   assign o_hi = count[15:8];
   assign o_lo = hold;
   assign o_sat = i_event && !i_rd_hi && count == CNT16_MAX - 16'h0001;

   default clocking cb16 @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence hi_then_lo_s;
      i_rd_hi ##1 i_rd_lo;
   endsequence

   c16_pair_a: assert property (hi_then_lo_s |-> o_lo == $past(count[7:0]))
      else $error("lower byte does not match upper-byte read");
   c16_hold_max_a: assert property (count == CNT16_MAX && !i_rd_hi |=> count == CNT16_MAX)
      else $error("16-bit counter wrapped");
endmodule // pmec_count16

// ### pmec_count8.sv
// saturating 8-bit event counter that clears when read
module pmec_count8 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_event,
   input wire logic i_rd,
   output logic [7:0] o_count,
   output logic o_sat
);
   import pmec_pkg::*;

   logic [7:0] count;

   // a read restarts from zero, but an event in the read cycle is kept
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count <= CNT8_RST;
      end else if (i_rd) begin
         count <= {7'h00, i_event};
      end else if (i_event && count != CNT8_MAX) begin
         count <= count + 8'h01;
      end
   end

   assign o_count = count;
   // pulse on the event that fills the counter
   assign o_sat = i_event && !i_rd && count == CNT8_MAX - 8'h01;

   default clocking cb8 @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   c8_hold_max_a: assert property (count == CNT8_MAX && !i_rd |=> count == CNT8_MAX)
      else $error("8-bit counter left its maximum without a read");
   c8_restart_a: assert property (i_rd |=> count == {7'h00, $past(i_event)})
      else $error("8-bit counter did not restart after read");
endmodule // pmec_count8

// ### pmec_pkg.sv
// shared constants and carrier types for the performance-monitor error counters
package pmec_pkg;

   // ---------------------------------------------------------------
   // bus and data widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] PRBS_HI_OFS = 16'h090D;
   localparam logic [15:0] PRBS_LO_OFS = 16'h090E;
   localparam logic [15:0] SLIP_OFS = 16'h090F;
   localparam logic [15:0] ZV_HI_OFS = 16'h0910;
   localparam logic [15:0] ZV_LO_OFS = 16'h0911;
   localparam logic [15:0] FCS2_OFS = 16'h091C;
   localparam logic [15:0] IRQ_STAT_OFS = 16'h0920;
   localparam logic [15:0] IRQ_MASK_OFS = 16'h0921;

   // ---------------------------------------------------------------
   // reset values, limits and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] CNT8_RST = 8'h00;
   localparam logic [15:0] CNT16_RST = 16'h0000;
   localparam logic [7:0] CNT8_MAX = 8'hFF;
   localparam logic [15:0] CNT16_MAX = 16'hFFFF;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   localparam int IRQ_PRBS_BIT = 0;
   localparam int IRQ_SLIP_BIT = 1;
   localparam int IRQ_ZV_BIT = 2;
   localparam int IRQ_FCS2_BIT = 3;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pmec_bus_t;

   typedef struct packed {
      logic pattern_bit_error;
      logic slip_repeat;
      logic slip_drop;
      logic zero_violation;
      logic lapd2_check_error;
   } pmec_events_t;

endpackage

// ### pmec_top.sv
// register bank of clear-on-read performance-monitor error counters
// What this block does
// - count pattern bit errors in sixteen bits
// - two-byte counters clear when read
// - eight-bit transmit slip count, cleared on read
// - frame repeat or drop counts one slip
// - count excessive-zero violations in sixteen bits
// - upper byte bits fifteen to eight
// - eight-bit LAPD2 check error count
// - eight-bit counters restart after each read
module pmec_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire pmec_pkg::pmec_bus_t i_bus,
   input wire pmec_pkg::pmec_events_t i_events,
   output logic [pmec_pkg::DATA_W-1:0] o_rdata,
   output logic o_irq
);
   import pmec_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic rd_pr_hi;
   logic rd_pr_lo;
   logic rd_slip;
   logic rd_zv_hi;
   logic rd_zv_lo;
   logic rd_fcs;
   logic rd_stat;
   logic [7:0] next_rdata;

   logic [7:0] pr_hi;
   logic [7:0] pr_lo;
   logic [7:0] zv_hi;
   logic [7:0] zv_lo;
   logic [7:0] slip_cnt;
   logic [7:0] fcs_cnt;

   logic pr_sat;
   logic zv_sat;
   logic slip_sat;
   logic fcs_sat;
   logic slip_event;

   logic [3:0] sat_vec;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------

   // one strobe per register except the mask, data picked in the same cycle and
   // registered below so it stands only in the following cycle
   always_comb begin
      rd_pr_hi = 1'b0;
      rd_pr_lo = 1'b0;
      rd_slip = 1'b0;
      rd_zv_hi = 1'b0;
      rd_zv_lo = 1'b0;
      rd_fcs = 1'b0;
      rd_stat = 1'b0;
      next_rdata = UNMAPPED_RD;
      if (i_bus.rd) begin
         if (i_bus.addr == PRBS_HI_OFS) begin
            rd_pr_hi = 1'b1;
            next_rdata = pr_hi;
         end else if (i_bus.addr == PRBS_LO_OFS) begin
            rd_pr_lo = 1'b1;
            next_rdata = pr_lo;
         end else if (i_bus.addr == SLIP_OFS) begin
            rd_slip = 1'b1;
            next_rdata = slip_cnt;
         end else if (i_bus.addr == ZV_HI_OFS) begin
            rd_zv_hi = 1'b1;
            next_rdata = zv_hi;
         end else if (i_bus.addr == ZV_LO_OFS) begin
            rd_zv_lo = 1'b1;
            next_rdata = zv_lo;
         end else if (i_bus.addr == FCS2_OFS) begin
            rd_fcs = 1'b1;
            next_rdata = fcs_cnt;
         end else if (i_bus.addr == IRQ_STAT_OFS) begin
            rd_stat = 1'b1;
            next_rdata = {4'h0, irq_stat};
         end else if (i_bus.addr == IRQ_MASK_OFS) begin
            next_rdata = {4'h0, irq_mask};
         end
      end
   end

   // read data register: zero whenever no read was made the cycle before,
   // so stale counts never linger on the bus
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= UNMAPPED_RD;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // counters
   // ---------------------------------------------------------------

   // pattern bit errors from the receive framer
   pmec_count16 u_pattern_bit_error_count (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_event(i_events.pattern_bit_error),
      .i_rd_hi(rd_pr_hi),
      .i_rd_lo(rd_pr_lo),
      .o_hi(pr_hi),
      .o_lo(pr_lo),
      .o_sat(pr_sat)
   );

   // excessive-zero violations from the receive framer
   pmec_count16 u_zero_violation_count (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_event(i_events.zero_violation),
      .i_rd_hi(rd_zv_hi),
      .i_rd_lo(rd_zv_lo),
      .o_hi(zv_hi),
      .o_lo(zv_lo),
      .o_sat(zv_sat)
   );

   // a repeated or a dropped frame is one slip; both in one cycle
   // cannot happen in a real slip buffer, and would count once
   assign slip_event = i_events.slip_repeat | i_events.slip_drop;

   pmec_count8 u_transmit_slip_tally (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_event(slip_event),
      .i_rd(rd_slip),
      .o_count(slip_cnt),
      .o_sat(slip_sat)
   );

   // frame check sequence errors of the second LAPD controller
   pmec_count8 u_lapd2_check_error_tally (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_event(i_events.lapd2_check_error),
      .i_rd(rd_fcs),
      .o_count(fcs_cnt),
      .o_sat(fcs_sat)
   );

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------

   // each status bit flags a counter that just reached all ones,
   // telling software to read it before counts are dropped
   always_comb begin
      sat_vec = IRQ_RST;
      sat_vec[IRQ_PRBS_BIT] = pr_sat;
      sat_vec[IRQ_SLIP_BIT] = slip_sat;
      sat_vec[IRQ_ZV_BIT] = zv_sat;
      sat_vec[IRQ_FCS2_BIT] = fcs_sat;
   end

   // sticky status, cleared by reading it; a new event in the clearing
   // cycle wins so it is never lost
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_stat <= IRQ_RST;
      end else if (rd_stat) begin
         irq_stat <= sat_vec;
      end else begin
         irq_stat <= irq_stat | sat_vec;
      end
   end

   // mask register, the only writable location; other writes are ignored
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_mask <= IRQ_RST;
      end else if (i_bus.wr && i_bus.addr == IRQ_MASK_OFS) begin
         irq_mask <= i_bus.wdata[3:0];
      end
   end

   // level interrupt, built from flops only
   assign o_irq = |(irq_stat & irq_mask);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence slip_read_s;
      i_bus.rd && i_bus.addr == SLIP_OFS;
   endsequence

   sequence zv_pair_s;
      rd_zv_hi ##1 rd_zv_lo;
   endsequence

   sequence pr_pair_s;
      rd_pr_hi ##1 rd_pr_lo;
   endsequence

   // slip count is returned on the next cycle and then restarts
   slip_read_a: assert property (slip_read_s |=> o_rdata == $past(slip_cnt))
      else $error("slip read returned wrong count");
   slip_clear_a: assert property (slip_read_s ##0 !slip_event |=> slip_cnt == 8'h00)
      else $error("slip count not cleared by read");
   // either kind of slip adds exactly one below the limit
   slip_step_a: assert property (slip_event && !rd_slip && slip_cnt != CNT8_MAX
      |=> slip_cnt == $past(slip_cnt) + 8'h01)
      else $error("slip event not counted once");
   // check error tally read and step by one
   fcs_read_a: assert property (rd_fcs |=> o_rdata == $past(fcs_cnt))
      else $error("check error tally read wrong");
   fcs_step_a: assert property (i_events.lapd2_check_error && !rd_fcs
      && fcs_cnt != CNT8_MAX |=> fcs_cnt == $past(fcs_cnt) + 8'h01)
      else $error("check error not counted");
   // upper byte then lower byte gives the pair frozen at the first read
   zv_pair_a: assert property (zv_pair_s |=> o_rdata == $past(zv_lo))
      else $error("zero violation lower byte mismatch");
   zv_clear_a: assert property (rd_zv_hi && !i_events.zero_violation
      |=> zv_hi == 8'h00 ##1 zv_hi == 8'h00 || $past(i_events.zero_violation))
      else $error("zero violation count not cleared");
   pr_pair_a: assert property (pr_pair_s |=> o_rdata == $past(pr_lo))
      else $error("pattern error lower byte mismatch");
   pr_hi_a: assert property (rd_pr_hi |=> o_rdata == $past(pr_hi))
      else $error("pattern error upper byte wrong");
   // a saturating count raises its status even while status is read
   stat_win_a: assert property (slip_sat && rd_stat |=> irq_stat[IRQ_SLIP_BIT])
      else $error("status set lost against read clear");
   irq_path_a: assert property (fcs_sat && irq_mask[IRQ_FCS2_BIT] && !i_bus.wr |=> o_irq)
      else $error("unmasked event did not raise interrupt");
   // bus stays quiet after an idle cycle
   idle_data_a: assert property (!i_bus.rd |=> o_rdata == UNMAPPED_RD)
      else $error("read data outside the read answer cycle");

   // ---------------------------------------------------------------
   // checks on reset, decode, mask and status
   // ---------------------------------------------------------------

   sequence mask_write_s;
      i_bus.wr && i_bus.addr == IRQ_MASK_OFS;
   endsequence

   sequence stat_read_s;
      rd_stat;
   endsequence

   // a read that hits no register; the mask has no strobe of its own
   sequence hole_read_s;
      i_bus.rd && i_bus.addr != IRQ_MASK_OFS && !rd_pr_hi && !rd_pr_lo && !rd_slip
         && !rd_zv_hi && !rd_zv_lo && !rd_fcs && !rd_stat;
   endsequence

   // the default disable would hide the cycle right after reset, which is
   // the one that matters here, so these two lift it
   rst_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)
      !i_rst_n |=> o_rdata == UNMAPPED_RD && !o_irq && irq_stat == IRQ_RST
         && irq_mask == IRQ_RST)
      else $error("reset left bus, status or mask set");
   rst_count_a: assert property (@(posedge i_clk) disable iff (1'b0)
      !i_rst_n |=> slip_cnt == CNT8_RST && fcs_cnt == CNT8_RST && pr_hi == CNT8_RST
         && pr_lo == CNT8_RST && zv_hi == CNT8_RST && zv_lo == CNT8_RST)
      else $error("reset left a counter running");

   // reads of empty addresses answer zero
   hole_read_a: assert property (hole_read_s |=> o_rdata == UNMAPPED_RD)
      else $error("unmapped read returned data");

   // only a write to the mask address changes the mask
   mask_write_a: assert property (mask_write_s |=> irq_mask == $past(i_bus.wdata[3:0]))
      else $error("mask write not taken");
   mask_keep_a: assert property (!(i_bus.wr && i_bus.addr == IRQ_MASK_OFS)
      |=> irq_mask == $past(irq_mask))
      else $error("mask changed without a mask write");
   mask_read_a: assert property (i_bus.rd && i_bus.addr == IRQ_MASK_OFS
      |=> o_rdata == {4'h0, $past(irq_mask)})
      else $error("mask read returned wrong value");

   // status is returned whole, then cleared unless a counter fills in
   // the very same cycle
   stat_read_a: assert property (stat_read_s |=> o_rdata == {4'h0, $past(irq_stat)})
      else $error("status read returned wrong value");
   stat_clear_a: assert property (stat_read_s ##0 (sat_vec == IRQ_RST) |=> irq_stat == IRQ_RST)
      else $error("status not cleared by its read");
   stat_keep_a: assert property (!rd_stat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
      else $error("status bit dropped without a read");

   // a status bit only rises after its own counter filled up
   slip_cause_a: assert property ($rose(irq_stat[IRQ_SLIP_BIT]) |-> $past(slip_sat))
      else $error("slip status set without saturation");
   zv_cause_a: assert property ($rose(irq_stat[IRQ_ZV_BIT]) |-> $past(zv_sat))
      else $error("zero violation status set without saturation");
   fcs_cause_a: assert property ($rose(irq_stat[IRQ_FCS2_BIT]) |-> $past(fcs_sat))
      else $error("check error status set without saturation");

   // the line falls only when status is read or the mask is written
   irq_fall_a: assert property ($fell(o_irq) |-> $past(rd_stat)
      || $past(i_bus.wr && i_bus.addr == IRQ_MASK_OFS))
      else $error("interrupt dropped with no read or mask write");

   // a full counter lands on all ones and flags it in status
   slip_full_a: assert property (slip_event && !rd_slip
      && slip_cnt == CNT8_MAX - 8'h01
      |=> slip_cnt == CNT8_MAX && irq_stat[IRQ_SLIP_BIT])
      else $error("slip counter did not saturate with its flag");
   zv_full_a: assert property (zv_sat
      |=> zv_hi == CNT8_MAX && irq_stat[IRQ_ZV_BIT])
      else $error("zero violation counter did not saturate with its flag");
   fcs_full_a: assert property (fcs_sat
      |=> fcs_cnt == CNT8_MAX && irq_stat[IRQ_FCS2_BIT])
      else $error("check error counter did not saturate with its flag");

   // counts stand still while no event and no read arrive
   slip_keep_a: assert property (!slip_event && !rd_slip
      |=> slip_cnt == $past(slip_cnt))
      else $error("slip count moved without an event");
   fcs_keep_a: assert property (!i_events.lapd2_check_error && !rd_fcs
      |=> fcs_cnt == $past(fcs_cnt))
      else $error("check error tally moved without an event");
   fcs_clear_a: assert property (rd_fcs && !i_events.lapd2_check_error
      |=> fcs_cnt == CNT8_RST)
      else $error("check error tally not cleared by read");

   // upper byte reads return the live upper byte; lower byte reads
   // empty the hold so a repeated lower read cannot count twice
   zv_hi_a: assert property (rd_zv_hi |=> o_rdata == $past(zv_hi))
      else $error("zero violation upper byte wrong");
   zv_lo_clear_a: assert property (rd_zv_lo |=> zv_lo == CNT8_RST)
      else $error("zero violation hold not emptied");
   pr_lo_clear_a: assert property (rd_pr_lo |=> pr_lo == CNT8_RST)
      else $error("pattern error hold not emptied");
   // a lower read on its own still answers from the hold
   zv_lo_read_a: assert property (rd_zv_lo |=> o_rdata == $past(zv_lo))
      else $error("zero violation lower byte read wrong");
   pr_lo_read_a: assert property (rd_pr_lo |=> o_rdata == $past(pr_lo))
      else $error("pattern error lower byte read wrong");

endmodule // pmec_top

// ### test_perf_monitor_error_counters.sv
// self-checking bench for the clear-on-read error counter bank
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp); end end

module test_perf_monitor_error_counters;
   timeunit 1ns;
   timeprecision 1ps;
   import pmec_pkg::*;

   typedef struct {
      pmec_events_t ev;
      int n;
      logic [15:0] a;
      bit wide;
      logic [7:0] hi;
      logic [7:0] lo;
   } pmec_row_t;

   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   pmec_bus_t bus = '0;
   pmec_events_t ev = '0;
   logic [7:0] o_rdata;
   logic o_irq;
   int failures = 0;
   int compares = 0;

   // event bits: pattern, repeat, drop, zero, lapd2 from msb down
   pmec_row_t rows [6] = '{
      '{5'h08, 3, SLIP_OFS, 1'b0, 8'h00, 8'h03},
      '{5'h04, 2, SLIP_OFS, 1'b0, 8'h00, 8'h02},
      '{5'h0C, 4, SLIP_OFS, 1'b0, 8'h00, 8'h04},
      '{5'h01, 5, FCS2_OFS, 1'b0, 8'h00, 8'h05},
      '{5'h10, 258, PRBS_HI_OFS, 1'b1, 8'h01, 8'h02},
      '{5'h02, 300, ZV_HI_OFS, 1'b1, 8'h01, 8'h2C}
   };

   // free-running 25 MHz clock
   always #20 i_clk = ~i_clk;

   pmec_top dut_u (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_bus(bus),
      .i_events(ev),
      .o_rdata(o_rdata),
      .o_irq(o_irq)
   );

   // ---------------------------------------------------------------
   // bus and event drivers, each starts and ends on a rising edge
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // an idle cycle after the burst keeps two pulses from meeting in one step
   task automatic pulse(input pmec_events_t m, input int n);
      repeat (n) begin
         ev <= m;
         @(posedge i_clk);
      end
      ev <= '0;
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1 `CHK(o_rdata, e)
      @(posedge i_clk);
   endtask

   // upper then lower byte with no gap, as software must do it
   task automatic rd16(input logic [15:0] a, input logic [7:0] hi, input logic [7:0] lo);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge i_clk);
      bus.addr <= a + 16'h0001;
      #1 `CHK(o_rdata, hi)
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1 `CHK(o_rdata, lo)
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge i_clk);
      bus.wr <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic chk_irq(input logic e);
      #1 `CHK(o_irq, e)
      @(posedge i_clk);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge i_clk);
      #1 `CHK(o_rdata, 8'h00)
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      // every counter and control register starts at zero
      for (int a = 16'h090D; a <= 16'h0911; a++) rd(a[15:0], 8'h00);
      rd(FCS2_OFS, 8'h00);
      rd(IRQ_MASK_OFS, 8'h00);
      chk_irq(1'b0);
      // table rows: count, read, then a second read must find zero
      foreach (rows[i]) begin
         pulse(rows[i].ev, rows[i].n);
         if (rows[i].wide) begin
            rd16(rows[i].a, rows[i].hi, rows[i].lo);
            rd16(rows[i].a, 8'h00, 8'h00);
         end else begin
            rd(rows[i].a, rows[i].lo);
            rd(rows[i].a, 8'h00);
         end
      end
      // events during the ordered read are kept for the next pair
      pulse(5'h02, 3);
      ev <= 5'h02;
      bus.rd <= 1'b1;
      bus.addr <= ZV_HI_OFS;
      @(posedge i_clk);
      bus.addr <= ZV_LO_OFS;
      #1 `CHK(o_rdata, 8'h00)
      @(posedge i_clk);
      bus.rd <= 1'b0;
      ev <= '0;
      #1 `CHK(o_rdata, 8'h03)
      @(posedge i_clk);
      #1 `CHK(o_rdata, 8'h00)
      @(posedge i_clk);
      rd16(ZV_HI_OFS, 8'h00, 8'h02);
      rd(ZV_LO_OFS, 8'h00);
      // writes to counters are ignored and holes read as zero
      pulse(5'h08, 1);
      wr(SLIP_OFS, 8'h55);
      rd(SLIP_OFS, 8'h01);
      rd(16'h0900, UNMAPPED_RD);
      // eight-bit saturation with the flag masked, then unmasked
      pulse(5'h08, 256);
      chk_irq(1'b0);
      rd(SLIP_OFS, 8'hFF);
      wr(IRQ_MASK_OFS, 8'h02);
      chk_irq(1'b1);
      rd(IRQ_MASK_OFS, 8'h02);
      rd(IRQ_STAT_OFS, 8'h02);
      chk_irq(1'b0);
      // sixteen-bit saturation; its flag stays masked
      pulse(5'h02, 65537);
      chk_irq(1'b0);
      rd16(ZV_HI_OFS, 8'hFF, 8'hFF);
      rd(IRQ_STAT_OFS, 8'h04);
      // check error saturation with its flag unmasked raises the line
      wr(IRQ_MASK_OFS, 8'h08);
      pulse(5'h01, 256);
      chk_irq(1'b1);
      rd(FCS2_OFS, 8'hFF);
      rd(IRQ_STAT_OFS, 8'h08);
      chk_irq(1'b0);
      // a second reset in mid-run drops pending counts and the mask
      pulse(5'h01, 2);
      i_rst_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(FCS2_OFS, 8'h00);
      rd(IRQ_MASK_OFS, 8'h00);
      rd(IRQ_STAT_OFS, 8'h00);
      chk_irq(1'b0);
      stop_test();
   end

   // the run needs about 67k cycles; a hang is cut off well past that
   initial begin
      repeat (80000) @(posedge i_clk);
      failures++;
      stop_test();
   end

endmodule // test_perf_monitor_error_counters
